// ===== logic/ebc_arbiter.v
`timescale 1ns/1ps
module ebc_arbiter
(
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	// requesters
	input wire hold_req_in,
	input wire dma_req_in,
	input wire cpu_req_in,
	input wire cpu_lock_in,
	// grant is only taken when the bus is free
	input wire take_in,
	output wire grant_hold_out,
	output wire grant_dma_out,
	output wire grant_cpu_out
);
	reg lock_reg;

	// the first half of a split odd word keeps the dma engine out until the second half
	assign grant_hold_out = hold_req_in; // [RULE_18]
	assign grant_dma_out = !hold_req_in && dma_req_in && !lock_reg; // [RULE_18] [RULE_19]
	assign grant_cpu_out = !hold_req_in && cpu_req_in && !(dma_req_in && !lock_reg); // [RULE_18]

	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			lock_reg <= 1'b0;
		else if (ce_in && take_in && grant_cpu_out)
			lock_reg <= cpu_lock_in; // [RULE_19]
	end
endmodule

// ===== logic/ebc_bus_ctrl.v
// What this block does
// [RULE_01] address bus width selectable 12, 16, 20
// [RULE_02] two port-select bits encode width; one combination illegal
// [RULE_03] address undefined until first external access
// [RULE_04] sixteen-line external data bus
// [RULE_05] width select pin held constant while running
// [RULE_06] each chip select pin port or select
// [RULE_07] 1 Mbyte: four areas; 4 Mbyte: bank number
// [RULE_08] strobe style selects BYTE_HIGH_ENABLE_N/WR or STORE_LOW_STROBE_N/STORE_HIGH_STROBE_N
// [RULE_09] separate style: low, high, both strobes
// [RULE_10] single style: byte enable plus address bit zero
// [RULE_11] ALE strobes address on multiplexed space
// [RULE_12] ready low at last falling edge adds wait
// [RULE_13] bus outputs frozen during a wait state
// [RULE_14] ready high at falling edge resumes cycle
// [RULE_15] ready honoured only when area wait bit zero
// [RULE_16] hold entered after current access, kept while low
// [RULE_17] grant pin low throughout hold
// [RULE_18] priority: hold, then dma engine, then cpu
// [RULE_19] no dma between halves of odd word
// [RULE_20] hold floats address, data, selects, strobes
// [RULE_21] hold floats port groups 0,1,3,4; freezes 6-10
// [RULE_22] watchdog stops during hold, peripherals run
// [RULE_23] multiplexed space: even addresses only, data on A1-A8
// [RULE_24] bus clock output at cpu rate when enabled
// [RULE_25] wait disabled area ignores ready input
`timescale 1ns/1ps
`include "ebc_defines.vh"
module ebc_bus_ctrl
(
	// clock, reset, enable
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	// configuration
	input wire expansion_mode_in,
	input wire upper_addr_port_select_in,
	input wire mid_addr_port_select_in,
	input wire strobe_style_select_in,
	input wire mem_4mb_mode_in,
	input wire [3:0] bank_num_in,
	input wire [3:0] chip_select_enable_n_in,
	input wire [3:0] chip_select_wait_sel_in,
	input wire [3:0] mux_area_in,
	input wire bclk_out_disable_in,
	// cpu request
	input wire cpu_req_in,
	input wire cpu_lock_in,
	input wire cpu_wr_in,
	input wire cpu_word_in,
	input wire [19:0] cpu_addr_in,
	input wire [15:0] cpu_wdata_in,
	output wire cpu_ack_out,
	// dma engine request
	input wire dma_req_in,
	input wire dma_wr_in,
	input wire dma_word_in,
	input wire [19:0] dma_addr_in,
	input wire [15:0] dma_wdata_in,
	output wire dma_ack_out,
	// read data of the last cycle
	output reg [15:0] rdata_out,
	// external pins
	output reg [19:0] addr_out,
	output reg [19:0] addr_oe_out,
	input wire [15:0] data_pin_in,
	output reg [15:0] data_out,
	output reg data_oe_out,
	output reg [3:0] chip_select_n_pin_out,
	output reg [3:0] chip_select_oe_out,
	output reg read_strobe_n_out,
	output reg store_low_strobe_n_out,
	output reg store_high_bhe_n_out,
	output reg strobe_oe_out,
	output reg addr_latch_enable_out,
	output wire bus_clock_out,
	output reg bus_yield_grant_n_out,
	input wire wait_request_n_in,
	input wire bus_yield_request_n_in,
	input wire width_select_pin_in,
	// status
	output wire [1:0] addr_width_out,
	output wire width_mode_error_out,
	output wire port_float_out,
	output wire port_freeze_out,
	output wire wdt_stop_out,
	output wire bus_busy_out
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_STRB = 3'h2;
	localparam [2:0] ST_WAIT = 3'h3;
	localparam [2:0] ST_END = 3'h4;
	localparam [2:0] ST_HOLD = 3'h5;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg phase_reg;
	reg addr_valid_reg;
	reg req_dma_reg;
	reg req_wr_reg;
	reg req_word_reg;
	reg [19:0] req_addr_reg;
	reg [15:0] req_wdata_reg;
	reg cpu_ack_reg;
	reg dma_ack_reg;

	wire rdy_n_sync;
	wire hold_n_sync;
	wire byte_sync;
	wire [15:0] data_sync;
	wire grant_hold;
	wire grant_dma;
	wire grant_cpu;
	wire fall;
	wire take;
	wire [1:0] area;
	wire area_mux;
	wire area_wait_en;
	wire style_sep;
	wire in_cycle;
	wire in_strobe;
	wire even_byte;
	wire odd_byte;

	// pins from the outside world pass two flops first
	ebc_sync2 #(.WIDTH(3), .RST_VAL(3'h7)) u_ctl_sync
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.async_in({wait_request_n_in, bus_yield_request_n_in, width_select_pin_in}),
		.sync_out({rdy_n_sync, hold_n_sync, byte_sync})
	);

	ebc_sync2 #(.WIDTH(16), .RST_VAL(`EBC_DATA_RST)) u_data_sync
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.async_in(data_pin_in),
		.sync_out(data_sync)
	);

	ebc_arbiter u_arb
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.hold_req_in(!hold_n_sync),
		.dma_req_in(dma_req_in),
		.cpu_req_in(cpu_req_in),
		.cpu_lock_in(cpu_lock_in),
		.take_in(take),
		.grant_hold_out(grant_hold),
		.grant_dma_out(grant_dma),
		.grant_cpu_out(grant_cpu)
	);

	// one bus state per bus clock period; the machine steps on its falling edge
	assign fall = ce_in && phase_reg;
	assign bus_clock_out = phase_reg && !bclk_out_disable_in; // [RULE_24]
	assign take = fall && state_reg == ST_IDLE && expansion_mode_in;

	assign area = req_addr_reg[`EBC_AREA_HI:`EBC_AREA_LO];
	assign area_mux = mux_area_in[area];
	assign area_wait_en = !chip_select_wait_sel_in[area]; // [RULE_15] [RULE_25]
	// the 8-bit bus (width pin high) only knows the single store strobe
	assign style_sep = strobe_style_select_in == `EBC_STYLE_SEPARATE && !byte_sync; // [RULE_08]
	assign in_cycle = state_reg == ST_ADDR || state_reg == ST_STRB || state_reg == ST_WAIT || state_reg == ST_END;
	assign in_strobe = state_reg == ST_STRB || state_reg == ST_WAIT;
	// a word is taken as even-aligned; an odd word is split by the cpu into two byte cycles
	assign even_byte = req_word_reg || !req_addr_reg[0] || area_mux;
	assign odd_byte = (req_word_reg || req_addr_reg[0]) && !area_mux && !byte_sync; // [RULE_23]

	assign addr_width_out = !mid_addr_port_select_in && !upper_addr_port_select_in ? `EBC_WIDTH_20 :
		!mid_addr_port_select_in ? `EBC_WIDTH_16 : `EBC_WIDTH_12; // [RULE_01] [RULE_02]
	assign width_mode_error_out = mid_addr_port_select_in && !upper_addr_port_select_in; // [RULE_02]
	assign port_float_out = state_reg == ST_HOLD; // [RULE_21]
	assign port_freeze_out = state_reg == ST_HOLD; // [RULE_21]
	assign wdt_stop_out = state_reg == ST_HOLD; // [RULE_22]
	assign bus_busy_out = state_reg != ST_IDLE;
	assign cpu_ack_out = cpu_ack_reg;
	assign dma_ack_out = dma_ack_reg;

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (!expansion_mode_in)
					state_next = ST_IDLE;
				else if (grant_hold)
					state_next = ST_HOLD; // [RULE_16]
				else if (grant_dma || grant_cpu)
					state_next = ST_ADDR;
			end
			ST_ADDR:
				state_next = ST_STRB;
			ST_STRB:
			begin
				if (!rdy_n_sync && area_wait_en)
					state_next = ST_WAIT; // [RULE_12]
				else
					state_next = ST_END; // [RULE_25]
			end
			ST_WAIT:
			begin
				if (rdy_n_sync)
					state_next = ST_END; // [RULE_14]
			end
			ST_END:
				state_next = ST_IDLE;
			ST_HOLD:
			begin
				if (hold_n_sync)
					state_next = ST_IDLE; // [RULE_16]
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg <= ST_IDLE;
			phase_reg <= 1'b0;
			addr_valid_reg <= 1'b0;
			req_dma_reg <= 1'b0;
			req_wr_reg <= 1'b0;
			req_word_reg <= 1'b0;
			req_addr_reg <= `EBC_ADDR_RST;
			req_wdata_reg <= `EBC_DATA_RST;
			cpu_ack_reg <= 1'b0;
			dma_ack_reg <= 1'b0;
			rdata_out <= `EBC_DATA_RST;
		end
		else if (ce_in)
		begin
			phase_reg <= !phase_reg;
			cpu_ack_reg <= 1'b0;
			dma_ack_reg <= 1'b0;
			if (!expansion_mode_in)
				addr_valid_reg <= 1'b0; // [RULE_03]
			if (fall)
			begin
				state_reg <= state_next;
				if (take && !grant_hold && (grant_dma || grant_cpu))
				begin
					addr_valid_reg <= 1'b1; // [RULE_03]
					req_dma_reg <= grant_dma;
					req_wr_reg <= grant_dma ? dma_wr_in : cpu_wr_in;
					req_word_reg <= grant_dma ? dma_word_in : cpu_word_in;
					req_addr_reg <= grant_dma ? dma_addr_in : cpu_addr_in;
					req_wdata_reg <= grant_dma ? dma_wdata_in : cpu_wdata_in;
				end
				if (state_reg == ST_END)
				begin
					// synchronised pins still show what stood during the strobe
					if (!req_wr_reg)
						rdata_out <= data_sync;
					cpu_ack_reg <= !req_dma_reg;
					dma_ack_reg <= req_dma_reg;
				end
			end
		end
	end

	// pin outputs follow state, latched request and configuration inputs, so a wait state freezes them
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			addr_out <= `EBC_ADDR_RST;
			addr_oe_out <= `EBC_ADDR_RST;
			data_out <= `EBC_DATA_RST;
			data_oe_out <= 1'b0;
			chip_select_n_pin_out <= `EBC_CS_RST;
			chip_select_oe_out <= 4'h0;
			read_strobe_n_out <= 1'b1;
			store_low_strobe_n_out <= 1'b1;
			store_high_bhe_n_out <= 1'b1;
			strobe_oe_out <= 1'b0;
			addr_latch_enable_out <= 1'b0;
			bus_yield_grant_n_out <= 1'b1;
		end
		else if (ce_in)
		begin
			bus_yield_grant_n_out <= state_reg != ST_HOLD; // [RULE_17]
			// hold floats address, data, select and strobe outputs; ALE is simply kept low there
			if (state_reg == ST_HOLD)
			begin
				addr_oe_out <= 20'h00000; // [RULE_20]
				data_oe_out <= 1'b0; // [RULE_20]
				chip_select_oe_out <= 4'h0; // [RULE_20]
				strobe_oe_out <= 1'b0; // [RULE_20]
				addr_latch_enable_out <= 1'b0;
			end
			else
			begin
				strobe_oe_out <= expansion_mode_in;
				chip_select_oe_out <= expansion_mode_in ? ~chip_select_enable_n_in : 4'h0; // [RULE_06]
				// old address lingers between cycles; nothing driven before the first access
				addr_oe_out <= {20{addr_valid_reg && expansion_mode_in}} &
					{{4{!upper_addr_port_select_in}}, {4{!mid_addr_port_select_in}}, 12'hFFF}; // [RULE_01] [RULE_03]
				if (in_cycle)
				begin
					addr_out <= req_addr_reg; // [RULE_13]
					if (area_mux)
					begin
						addr_out[0] <= 1'b0; // [RULE_23]
						if (in_strobe || state_reg == ST_END)
						begin
							addr_out[`EBC_MUX_HI:`EBC_MUX_LO] <= req_wdata_reg[7:0]; // [RULE_23]
							if (!req_wr_reg)
								addr_oe_out[`EBC_MUX_HI:`EBC_MUX_LO] <= 8'h00;
						end
					end
				end
				addr_latch_enable_out <= state_reg == ST_ADDR && !phase_reg && area_mux; // [RULE_11] address outlives it
				data_out <= req_wdata_reg;
				data_oe_out <= in_cycle && state_reg != ST_ADDR && req_wr_reg && !area_mux; // [RULE_04]
				if (in_cycle)
				begin
					if (mem_4mb_mode_in)
						chip_select_n_pin_out <= bank_num_in; // [RULE_07]
					else
						chip_select_n_pin_out <= ~(4'h1 << area); // [RULE_07]
				end
				else if (!mem_4mb_mode_in)
					chip_select_n_pin_out <= `EBC_CS_RST;
				read_strobe_n_out <= !(in_strobe && !req_wr_reg); // [RULE_09] [RULE_10]
				if (style_sep)
				begin
					store_low_strobe_n_out <= !(in_strobe && req_wr_reg && even_byte); // [RULE_09]
					store_high_bhe_n_out <= !(in_strobe && req_wr_reg && odd_byte); // [RULE_09]
				end
				else
				begin
					store_low_strobe_n_out <= !(in_strobe && req_wr_reg); // [RULE_10]
					store_high_bhe_n_out <= !(in_cycle && odd_byte); // [RULE_10]
				end
			end
		end
	end
endmodule

// ===== logic/ebc_defines.vh
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH

// bus dimensions
`define EBC_ADDR_W 20
`define EBC_DATA_W 16
`define EBC_CS_N 4

// address line groups that may fall back to port pins
`define EBC_MID_LO 12
`define EBC_MID_HI 15
`define EBC_UPPER_LO 16
`define EBC_UPPER_HI 19
// multiplexed low data byte rides on these address lines
`define EBC_MUX_LO 1
`define EBC_MUX_HI 8
// area select bits of the 1 Mbyte space
`define EBC_AREA_HI 19
`define EBC_AREA_LO 18

// address width codes for addr_width_out
`define EBC_WIDTH_12 2'h0
`define EBC_WIDTH_16 2'h1
`define EBC_WIDTH_20 2'h2

// strobe styles
`define EBC_STYLE_SINGLE 1'h0
`define EBC_STYLE_SEPARATE 1'h1

// reset values
`define EBC_ADDR_RST 20'h00000
`define EBC_DATA_RST 16'h0000
`define EBC_CS_RST 4'hF

`endif

// ===== logic/ebc_sync2.v
`timescale 1ns/1ps
module ebc_sync2 #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	// level from outside the clock domain
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end
		else if (ce_in)
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// ===== verification/ebc_bus_ctrl_checker.sv
`timescale 1ns/1ps
module ebc_bus_ctrl_checker
(
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	// configuration
	input wire upper_addr_port_select_in,
	input wire mid_addr_port_select_in,
	input wire strobe_style_select_in,
	input wire [3:0] chip_select_enable_n_in,
	input wire [3:0] chip_select_wait_sel_in,
	input wire bclk_out_disable_in,
	input wire wait_request_n_in,
	// pins and status
	input wire [19:0] addr_out,
	input wire [19:0] addr_oe_out,
	input wire data_oe_out,
	input wire [3:0] chip_select_n_pin_out,
	input wire [3:0] chip_select_oe_out,
	input wire read_strobe_n_out,
	input wire store_low_strobe_n_out,
	input wire store_high_bhe_n_out,
	input wire strobe_oe_out,
	input wire addr_latch_enable_out,
	input wire bus_clock_out,
	input wire bus_yield_grant_n_out,
	input wire [1:0] addr_width_out,
	input wire width_mode_error_out,
	input wire port_float_out,
	input wire wdt_stop_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// wait bit of the area that the current address falls in
	wire wsel = chip_select_wait_sel_in[addr_out[19:18]];
	sequence rd_start;
		$fell(read_strobe_n_out);
	endsequence
	sequence rd_nominal;
		!read_strobe_n_out[*2] ##1 read_strobe_n_out;
	endsequence
	AST_WIDTH16: assert property ((!mid_addr_port_select_in && upper_addr_port_select_in)[*2] |->
		addr_width_out == 2'h1 && !width_mode_error_out) else $error("width 16 wrong");
	AST_WIDTH20: assert property ((!mid_addr_port_select_in && !upper_addr_port_select_in)[*2] |->
		addr_width_out == 2'h2) else $error("width 20 wrong");
	AST_WIDTH_BAD: assert property ((mid_addr_port_select_in && !upper_addr_port_select_in)[*2] |->
		width_mode_error_out) else $error("illegal width not flagged");
	AST_HOLD_GRANT: assert property (port_float_out |-> wdt_stop_out ##1 !bus_yield_grant_n_out)
		else $error("hold without grant");
	AST_HOLD_FLOAT: assert property (!bus_yield_grant_n_out |-> addr_oe_out == 20'h00000 && !data_oe_out &&
		chip_select_oe_out == 4'h0 && !strobe_oe_out) else $error("bus driven in hold");
	AST_NOMINAL: assert property (rd_start ##0 wsel |-> rd_nominal) else $error("wait in disabled area");
	AST_WAIT: assert property (rd_start ##0 (!wsel && !$past(wait_request_n_in, 2)) |->
		!read_strobe_n_out[*4]) else $error("wait state missing");
	AST_FREEZE: assert property (!read_strobe_n_out[*2] |-> $stable(addr_out) &&
		$stable(chip_select_n_pin_out) && $stable(bus_yield_grant_n_out)) else $error("pins moved in strobe");
	AST_BCLK: assert property (!$past(rst_in) && ce_in && $past(ce_in) && !bclk_out_disable_in &&
		!$past(bclk_out_disable_in) |-> bus_clock_out != $past(bus_clock_out)) else $error("bus clock stalled");
	AST_CS_PORT: assert property ($stable(chip_select_enable_n_in) |->
		(chip_select_oe_out & chip_select_enable_n_in) == 4'h0) else $error("port pin driven as select");
	AST_SEP: assert property (strobe_style_select_in && !read_strobe_n_out |->
		store_low_strobe_n_out && store_high_bhe_n_out) else $error("store strobe in read");
	AST_ALE_EVEN: assert property (addr_latch_enable_out |-> !addr_out[0]) else $error("odd mux address");
endmodule
bind ebc_bus_ctrl ebc_bus_ctrl_checker chk (.*);

// ===== verification/ebc_ext_mem.sv
`timescale 1ns/1ps
module ebc_ext_mem
(
	// clock and test controls
	input wire clk_in,
	input wire slow_in,
	input wire style_in,
	input wire mux_in,
	// bus from the controller
	input wire [19:0] addr_in,
	input wire [15:0] wdata_in,
	input wire rd_n_in,
	input wire st_lo_n_in,
	input wire st_hi_n_in,
	input wire ale_in,
	// answers
	output wire [15:0] data_drv_out,
	output wire ready_n_out
);
	reg [15:0] mem [0:255];
	reg [15:0] last_reg = 16'h0000;
	reg [7:0] lat_reg = 8'h00;
	wire [7:0] a = mux_in ? lat_reg : addr_in[8:1];
	wire [15:0] wd = mux_in ? {8'h00, addr_in[8:1]} : wdata_in;
	// byte enable alone is not a strobe in single style, it may stand for the whole cycle
	wire act = !rd_n_in || !st_lo_n_in || (style_in && !st_hi_n_in);
	wire lo_we = style_in ? !st_lo_n_in : (!st_lo_n_in && !addr_in[0]);
	wire hi_we = style_in ? !st_hi_n_in : (!st_lo_n_in && !st_hi_n_in);
	// released bus shows the inverse of its last value, never a stale match
	assign data_drv_out = !rd_n_in ? mem[a] : ~last_reg;
	// slow device holds ready low until its strobe shows; the two sync flops make that exactly one wait
	assign ready_n_out = !(slow_in && !act);
	always @(negedge ale_in)
		lat_reg <= addr_in[8:1];
	always @(posedge clk_in)
	begin
		if (lo_we)
			mem[a][7:0] <= wd[7:0];
		if (hi_we)
			mem[a][15:8] <= wd[15:8];
		last_reg <= data_drv_out;
	end
endmodule

// ===== verification/test_ebc_bus_ctrl.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((ex) !== (got)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module test_ebc_bus_ctrl;
	typedef struct packed {logic st; logic slow; logic ws; logic wd; logic [19:0] a; logic [7:0] b;
		logic [3:0] len; logic [3:0] cs;} ebc_row_t;
	logic clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, expansion_mode_in = 1'b1;
	logic width_select_pin_in = 1'b0;
	logic upper_addr_port_select_in = 1'b0, mid_addr_port_select_in = 1'b0, strobe_style_select_in = 1'b0;
	logic mem_4mb_mode_in = 1'b0, bclk_out_disable_in = 1'b0, bus_yield_request_n_in = 1'b1, slow = 1'b0, mux_on = 1'b0;
	logic [3:0] bank_num_in = 4'h0, chip_select_enable_n_in = 4'h0, chip_select_wait_sel_in = 4'h0, mux_area_in = 4'h0;
	logic cpu_req_in = 1'b0, cpu_lock_in = 1'b0, cpu_wr_in = 1'b0, cpu_word_in = 1'b1;
	logic dma_req_in = 1'b0, dma_wr_in = 1'b0, dma_word_in = 1'b1;
	logic [19:0] cpu_addr_in = 20'h00000, dma_addr_in = 20'h00020;
	logic [15:0] cpu_wdata_in = 16'h0000, dma_wdata_in = 16'h0000;
	wire cpu_ack_out, dma_ack_out, data_oe_out, read_strobe_n_out, store_low_strobe_n_out, store_high_bhe_n_out;
	wire strobe_oe_out, addr_latch_enable_out, bus_clock_out, bus_yield_grant_n_out, width_mode_error_out;
	wire port_float_out, port_freeze_out, wdt_stop_out, bus_busy_out, wait_request_n_in;
	wire [1:0] addr_width_out;
	wire [3:0] chip_select_n_pin_out, chip_select_oe_out;
	wire [15:0] rdata_out, data_out, data_pin_in;
	wire [19:0] addr_out, addr_oe_out;
	int n_fail = 0, checked = 0, cpu_n = 0, dma_n = 0, rdlen, i, k;
	logic [3:0] cs_seen;
	logic ale_seen, bc;
	logic [15:0] exp_w;
	ebc_row_t r;
	ebc_row_t rows [6] = '{'{1'b1, 1'b0, 1'b0, 1'b1, 20'h00010, 8'h3C, 4'h2, 4'hE},
		'{1'b1, 1'b0, 1'b0, 1'b0, 20'h40021, 8'h5A, 4'h2, 4'hD}, '{1'b0, 1'b0, 1'b0, 1'b0, 20'h40022, 8'hC3, 4'h2, 4'hD},
		'{1'b0, 1'b1, 1'b0, 1'b0, 20'h80033, 8'h96, 4'h4, 4'hB}, '{1'b0, 1'b1, 1'b1, 1'b1, 20'hC0040, 8'h69, 4'h2, 4'h7},
		'{1'b1, 1'b1, 1'b0, 1'b0, 20'hC0044, 8'hE1, 4'h4, 4'h7}};
	logic [2:0] wexp [4] = '{3'h2, 3'h1, 3'h4, 3'h0};
	ebc_bus_ctrl dut (.*);
	ebc_ext_mem mem (.clk_in(clk_in), .slow_in(slow), .style_in(strobe_style_select_in), .mux_in(mux_on),
		.addr_in(addr_out), .wdata_in(data_out), .rd_n_in(read_strobe_n_out), .st_lo_n_in(store_low_strobe_n_out),
		.st_hi_n_in(store_high_bhe_n_out), .ale_in(addr_latch_enable_out), .data_drv_out(data_pin_in),
		.ready_n_out(wait_request_n_in));
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		if (cpu_ack_out === 1'b1)
			cpu_n++;
		if (dma_ack_out === 1'b1)
			dma_n++;
	end
	task automatic op(input logic w, input logic wd, input logic [19:0] a, input logic [15:0] d);
		int j;
		rdlen = 0;
		ale_seen = 1'b0;
		cpu_wr_in = w;
		cpu_word_in = wd;
		cpu_addr_in = a;
		cpu_wdata_in = d;
		cpu_req_in = 1'b1;
		for (j = 0; j < 60 && cpu_ack_out !== 1'b1; j++)
		begin
			@(posedge clk_in);
			#1;
			if (read_strobe_n_out === 1'b0)
				rdlen++;
			if ((read_strobe_n_out & store_low_strobe_n_out) === 1'b0)
				cs_seen = chip_select_n_pin_out;
			ale_seen = ale_seen | addr_latch_enable_out;
		end
		`CHK("cpu ack", 1'b1, cpu_ack_out)
		@(negedge clk_in);
		cpu_req_in = 1'b0;
		// let the ack pulse die so the next call does not see it
		@(negedge clk_in);
	endtask
	task automatic wait_ack(input logic dma);
		int j;
		for (j = 0; j < 80 && (dma ? dma_ack_out : cpu_ack_out) !== 1'b1; j++)
		begin
			@(posedge clk_in);
			#1;
		end
		@(negedge clk_in);
		if (dma)
			dma_req_in = 1'b0;
		else
			cpu_req_in = 1'b0;
		@(negedge clk_in);
	endtask
	task final_report;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#50000;
		n_fail++;
		final_report;
	end
	initial
	begin
		repeat (3) @(negedge clk_in);
		`CHK("grant in reset", 1'b1, bus_yield_grant_n_out)
		`CHK("cs oe in reset", 4'h0, chip_select_oe_out)
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_in);
		`CHK("addr oe before access", 20'h00000, addr_oe_out)
		for (i = 0; i < 4; i++)
		begin
			{mid_addr_port_select_in, upper_addr_port_select_in} = i[1:0];
			repeat (3) @(negedge clk_in);
			`CHK("width", wexp[i], {width_mode_error_out, addr_width_out})
		end
		{mid_addr_port_select_in, upper_addr_port_select_in} = 2'h0;
		chip_select_enable_n_in = 4'h5;
		repeat (2) @(negedge clk_in);
		`CHK("cs oe", 4'hA, chip_select_oe_out)
		chip_select_enable_n_in = 4'h0;
		$display("config tests done");
		foreach (rows[k])
		begin
			r = rows[k];
			strobe_style_select_in = r.st;
			slow = r.slow;
			chip_select_wait_sel_in = {4{r.ws}};
			op(1'b1, 1'b1, {r.a[19:1], 1'b0}, 16'h0000);
			op(1'b1, r.wd, r.a, {r.b, r.b});
			op(1'b0, 1'b1, {r.a[19:1], 1'b0}, 16'h0000);
			exp_w = r.wd ? {r.b, r.b} : (r.a[0] ? {r.b, 8'h00} : {8'h00, r.b});
			`CHK("read data", exp_w, rdata_out)
			`CHK("strobe length", r.len, rdlen[3:0])
			`CHK("chip select", r.cs, cs_seen)
		end
		slow = 1'b0;
		$display("row tests done");
		cpu_lock_in = 1'b1;
		op(1'b0, 1'b0, 20'h00011, 16'h0000);
		k = dma_n;
		cpu_lock_in = 1'b0;
		dma_req_in = 1'b1;
		op(1'b0, 1'b0, 20'h00012, 16'h0000);
		`CHK("dma between halves", k, dma_n)
		wait_ack(1'b1);
		`CHK("dma after cpu", k + 1, dma_n)
		$display("lock test done");
		dma_wr_in = 1'b1;
		dma_wdata_in = 16'h1234;
		dma_addr_in = 20'h00030;
		fork
			op(1'b1, 1'b1, 20'h00050, 16'h0F0F);
			begin
				repeat (3) @(negedge clk_in);
				bus_yield_request_n_in = 1'b0;
			end
		join
		repeat (8) @(negedge clk_in);
		`CHK("grant", 1'b0, bus_yield_grant_n_out)
		`CHK("float in hold", 20'h00000, addr_oe_out)
		`CHK("port and wdt", 4'hF, {port_float_out, port_freeze_out, wdt_stop_out, bus_busy_out})
		i = dma_n;
		k = cpu_n;
		dma_req_in = 1'b1;
		cpu_req_in = 1'b1;
		repeat (20) @(negedge clk_in);
		`CHK("no ack in hold", {k, i}, {cpu_n, dma_n})
		bus_yield_request_n_in = 1'b1;
		wait_ack(1'b1);
		`CHK("dma first", k, cpu_n)
		wait_ack(1'b0);
		`CHK("cpu after hold", k + 1, cpu_n)
		`CHK("grant off", 1'b1, bus_yield_grant_n_out)
		$display("hold test done");
		mux_area_in = 4'h4;
		mux_on = 1'b1;
		op(1'b1, 1'b1, 20'h80100, 16'h00A5);
		op(1'b0, 1'b1, 20'h80100, 16'h0000);
		`CHK("mux read", 8'hA5, rdata_out[7:0])
		`CHK("ale", 1'b1, ale_seen)
		mux_area_in = 4'h0;
		mux_on = 1'b0;
		mem_4mb_mode_in = 1'b1;
		bank_num_in = 4'h9;
		op(1'b0, 1'b1, 20'h00010, 16'h0000);
		`CHK("bank number", 4'h9, cs_seen)
		mem_4mb_mode_in = 1'b0;
		bclk_out_disable_in = 1'b1;
		bc = 1'b0;
		repeat (2) @(negedge clk_in);
		repeat (4) @(negedge clk_in) bc = bc | bus_clock_out;
		`CHK("bus clock held", 1'b0, bc)
		bclk_out_disable_in = 1'b0;
		$display("mode tests done");
		final_report;
	end
endmodule
